// ### hw/modulo_timer_pkg.sv
package modulo_timer_pkg;
  // ------------------------------------------------------------
  // register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS_CTRL = 8'h2c;
  localparam logic [7:0] IDX_CNT_HIGH = 8'h2e;
  localparam logic [7:0] IDX_CNT_LOW = 8'h2f;
  localparam logic [7:0] IDX_MOD_HIGH = 8'h30;
  localparam logic [7:0] IDX_MOD_LOW = 8'h31;

  // ------------------------------------------------------------
  // status/control field positions
  // ------------------------------------------------------------
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_OVF_IE = 6;
  localparam int BIT_HALT = 5;
  localparam int BIT_CLEAR = 4;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 2;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic RST_HALT = 1'b1;
  localparam logic RST_OVF_IE = 1'b0;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [15:0] RST_MOD = 16'hffff;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [2:0] SEL_EXT_PIN = 3'h7;
  localparam int PRESCALE_W = 6;
endpackage

// ### hw/count_prescaler.sv
`timescale 1ns/1ps
// one-cycle count tick from the bus clock or the external pin
module count_prescaler #(
  parameter int DIV_W = modulo_timer_pkg::PRESCALE_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic clr,
  input wire logic [2:0] sel,
  // external count clock
  input wire logic ext_in,
  // tick out
  output logic tick
);
  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (DIV_W < 6) begin : g_chk
    $error("count_prescaler: DIV_W must reach divide by 64");
  end

  logic [DIV_W-1:0] div_r; // free divider, frozen while idle
  logic ext_prev_r; // previous pin level for edge detect
  logic [DIV_W-1:0] mask; // low bits that must be all ones

  // divider advances only while running, so stop keeps its phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (clr) begin
      div_r <= '0;
    end else if (run) begin
      div_r <= div_r + 1'b1;
    end
  end

  // pin is synchronous, one stage suffices for a rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_in;
    end
  end

  // divide by two to the sel: tick when the low sel bits are ones
  always_comb begin
    mask = DIV_W'((1 << sel) - 1);
    if (!run) begin
      tick = 1'b0;
    end else if (sel == modulo_timer_pkg::SEL_EXT_PIN) begin
      tick = ext_in && !ext_prev_r;
    end else begin
      tick = (div_r & mask) == mask;
    end
  end
endmodule

// ### hw/modulo_timer_counter_core.sv
`timescale 1ns/1ps
// How it works
// R1 - counts in wait; bus access refused
// R2 - enabled overflow request wakes from wait
// R3 - stop freezes counter and prescaler
// R4 - break holds the counter
// R5 - break without allow: flags unchanged
// R6 - break with allow: clears stick
// R7 - select divides by 1..64 or pin
// R8 - pin forced input when selected
// R9 - flag sets on rollover to zero
// R10 - read-then-write-zero clears flag safely
// R11 - request equals flag and enable
// R12 - halt set at reset, stops counting
// R13 - clear bit zeroes counter and prescaler
// R14 - halt with clear holds zero
// R15 - high read latches low byte
// R16 - software reads low before leaving break
// R17 - counter equal modulo wraps next tick
// R18 - high modulo write blocks flag until low
// R19 - modulo resets to all ones
// R20 - software clears counter before modulo write
// R21 - software leaves halt clear before wait
// R22 - increments per tick when running
module modulo_timer_counter_core #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // system states
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_state,
  input wire logic break_clear_allow,
  // external count clock pin
  input wire logic ext_count_clock_pin,
  input wire logic port_direction_bit,
  output logic ext_pin_oe,
  // to channels and cpu
  output logic [CNT_W-1:0] count_value,
  output logic overflow_pulse,
  output logic irq
);
  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (CNT_W != 16) begin : g_chk
    $error("modulo_timer_counter_core: registers are two bytes");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [CNT_W-1:0] cnt_r; // counter
  logic [CNT_W-1:0] mod_r; // modulo value
  logic [7:0] low_buf_r; // latched low byte
  logic [7:0] low_snap_r; // low byte seen at the edge the high byte answer was taken
  logic low_latched_r; // buffer holds a coherent low byte
  logic flag_r; // overflow flag
  logic ie_r; // overflow interrupt enable
  logic halt_r; // counter halt
  logic [2:0] sel_r; // clock divider select
  logic arm_r; // first clear step done
  logic mod_block_r; // high modulo written, low pending
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic oe_r;
  logic ovf_pulse_r;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = a == {idx, 2'b00};
  endfunction

  logic acc_go; // access phase, answer pending
  logic done; // completion edge of a transfer
  logic ok; // transfer is served (not in wait mode)
  logic wr;
  logic rd;
  logic wr_st;
  logic rd_st;
  logic rd_ch;
  logic rd_cl;
  logic wr_mh;
  logic wr_ml;
  logic wr_clr;
  logic protect; // break without clear allowance
  logic run;
  logic tick;
  logic wrap;
  logic ovf_set;

  assign acc_go = psel && penable && !pready_r;
  assign done = psel && penable && pready_r;
  assign ok = !pslverr_r;
  assign wr = done && ok && pwrite;
  assign rd = done && ok && !pwrite;
  assign wr_st = wr && hit(paddr, modulo_timer_pkg::IDX_STATUS_CTRL);
  assign rd_st = rd && hit(paddr, modulo_timer_pkg::IDX_STATUS_CTRL);
  assign rd_ch = rd && hit(paddr, modulo_timer_pkg::IDX_CNT_HIGH);
  assign rd_cl = rd && hit(paddr, modulo_timer_pkg::IDX_CNT_LOW);
  assign wr_mh = wr && hit(paddr, modulo_timer_pkg::IDX_MOD_HIGH);
  assign wr_ml = wr && hit(paddr, modulo_timer_pkg::IDX_MOD_LOW);
  assign wr_clr = wr_st && pwdata[modulo_timer_pkg::BIT_CLEAR]; // [R13]
  assign protect = break_state && !break_clear_allow; // [R5]

  // ------------------------------------------------------------
  // apb answer: one wait state, then ready with data
  // ------------------------------------------------------------
  // registers are closed to the cpu in wait mode; answer with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (acc_go) begin
      pready_r <= 1'b1;
      pslverr_r <= wait_mode; // [R1]
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // read data sampled one edge before completion; the low byte is snapped at that
  // same edge, so a latch made at completion matches the high byte already answered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      low_snap_r <= 8'h00;
    end else if (acc_go && !pwrite && !wait_mode) begin
      if (hit(paddr, modulo_timer_pkg::IDX_STATUS_CTRL)) begin
        // clear bit and reserved bit read as zero
        prdata_r <= {24'h00_0000, flag_r, ie_r, halt_r, 2'b00, sel_r};
      end else if (hit(paddr, modulo_timer_pkg::IDX_CNT_HIGH)) begin
        prdata_r <= {24'h00_0000, cnt_r[15:8]};
        low_snap_r <= cnt_r[7:0]; // [R15]
      end else if (hit(paddr, modulo_timer_pkg::IDX_CNT_LOW)) begin
        prdata_r <= {24'h00_0000, low_latched_r ? low_buf_r : cnt_r[7:0]}; // [R15]
      end else if (hit(paddr, modulo_timer_pkg::IDX_MOD_HIGH)) begin
        prdata_r <= {24'h00_0000, mod_r[15:8]};
      end else if (hit(paddr, modulo_timer_pkg::IDX_MOD_LOW)) begin
        prdata_r <= {24'h00_0000, mod_r[7:0]};
      end else begin
        // unmapped reads return zero without error
        prdata_r <= 32'h0000_0000;
      end
    end else if (acc_go) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  // halt starts set so the counter idles until software releases it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_r <= modulo_timer_pkg::RST_HALT; // [R12]
      ie_r <= modulo_timer_pkg::RST_OVF_IE; // [R11]
      sel_r <= modulo_timer_pkg::RST_SEL;
    end else if (wr_st) begin
      halt_r <= pwdata[modulo_timer_pkg::BIT_HALT]; // [R12]
      ie_r <= pwdata[modulo_timer_pkg::BIT_OVF_IE];
      sel_r <= pwdata[modulo_timer_pkg::SEL_MSB:modulo_timer_pkg::SEL_LSB]; // [R7]
    end
  end

  // ------------------------------------------------------------
  // prescaler and counter
  // ------------------------------------------------------------
  assign run = !halt_r && !stop_mode && !break_state; // [R22] [R3] [R4]

  count_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .clr(wr_clr),
    .sel(sel_r),
    .ext_in(ext_count_clock_pin),
    .tick(tick)
  );

  assign wrap = tick && (cnt_r == mod_r); // [R17]
  assign ovf_set = wrap && !mod_block_r && !wr_clr; // [R18] [R9]

  // clear wins over a tick; with halt in the same write it rests at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= modulo_timer_pkg::RST_CNT;
    end else if (wr_clr) begin
      cnt_r <= modulo_timer_pkg::RST_CNT; // [R13] [R14]
    end else if (wrap) begin
      cnt_r <= modulo_timer_pkg::RST_CNT; // [R17]
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1; // [R22]
    end
  end

  // modulo bytes; high write holds off the flag until low arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_r <= modulo_timer_pkg::RST_MOD; // [R19]
      mod_block_r <= 1'b0;
    end else begin
      if (wr_mh) begin
        mod_r[15:8] <= pwdata[7:0];
      end
      if (wr_ml) begin
        mod_r[7:0] <= pwdata[7:0];
      end
      if (wr_ml) begin
        mod_block_r <= 1'b0;
      end else if (wr_mh) begin
        mod_block_r <= 1'b1; // [R18]
      end
    end
  end

  // ------------------------------------------------------------
  // coherent counter read
  // ------------------------------------------------------------
  // a stale latch survives a break if software skips the low read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_buf_r <= 8'h00;
      low_latched_r <= 1'b0;
    end else if (wr_clr) begin
      low_buf_r <= 8'h00; // [R13]
      low_latched_r <= 1'b0;
    end else if (rd_ch && !low_latched_r) begin
      low_buf_r <= low_snap_r; // [R15]
      low_latched_r <= 1'b1;
    end else if (rd_cl) begin
      low_latched_r <= 1'b0; // [R16]
    end
  end

  // ------------------------------------------------------------
  // overflow flag and two-step clear
  // ------------------------------------------------------------
  // a new overflow always beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
      arm_r <= 1'b0;
    end else if (ovf_set) begin
      flag_r <= 1'b1; // [R9]
      arm_r <= 1'b0; // [R10]
    end else if (wr_st && !protect && arm_r && !pwdata[modulo_timer_pkg::BIT_OVF_FLAG]) begin
      flag_r <= 1'b0; // [R10] [R6]
      arm_r <= 1'b0;
    end else if (rd_st && !protect && flag_r) begin
      arm_r <= 1'b1; // [R10] [R5]
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // request is not masked by wait so it can wake the processor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      ovf_pulse_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      irq_r <= flag_r && ie_r; // [R11] [R2]
      ovf_pulse_r <= ovf_set;
      oe_r <= port_direction_bit && (sel_r != modulo_timer_pkg::SEL_EXT_PIN); // [R8]
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign count_value = cnt_r;
  assign overflow_pulse = ovf_pulse_r;
  assign irq = irq_r;
  assign ext_pin_oe = oe_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_WAIT_REFUSE: assert property ( // [R1]
    acc_go && wait_mode |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("access in wait mode not refused");

  AST_WAKE_IRQ: assert property ( // [R2]
    wait_mode && flag_r && ie_r |=> irq)
    else $error("enabled overflow did not request in wait");

  AST_STOP_HOLD: assert property ( // [R3]
    stop_mode && !wr_clr |=> $stable(cnt_r))
    else $error("counter moved in stop mode");

  AST_BREAK_HOLD: assert property ( // [R4]
    break_state && !wr_clr |=> $stable(cnt_r))
    else $error("counter moved in break");

  AST_PROTECT: assert property ( // [R5]
    protect && !ovf_set |=> flag_r == $past(flag_r))
    else $error("flag changed in protected break");

  AST_EXT_INPUT: assert property ( // [R8]
    sel_r == modulo_timer_pkg::SEL_EXT_PIN |=> !ext_pin_oe)
    else $error("pin driven while selected as count clock");

  AST_OVF_WRAP: assert property ( // [R9]
    ovf_set |=> flag_r && cnt_r == 16'h0000 && overflow_pulse)
    else $error("overflow did not set flag and wrap");

  AST_NO_ARM_KEEP: assert property ( // [R10]
    wr_st && flag_r && !arm_r |=> flag_r)
    else $error("flag cleared without prior status read");

  AST_IRQ_PAIR: assert property ( // [R11]
    irq |-> $past(flag_r) && $past(ie_r))
    else $error("request without flag and enable");

  AST_HALT: assert property ( // [R12]
    halt_r && !wr_clr |=> $stable(cnt_r))
    else $error("counter moved while halted");

  AST_CLEAR: assert property ( // [R13]
    wr_clr |=> cnt_r == 16'h0000 && !low_latched_r)
    else $error("clear did not zero counter");

  AST_LATCH: assert property ( // [R15]
    low_latched_r && !rd_cl && !wr_clr |=> $stable(low_buf_r) && low_latched_r)
    else $error("latched low byte disturbed");

  AST_MOD_BLOCK: assert property ( // [R18]
    mod_block_r && !flag_r |=> !flag_r)
    else $error("flag set while modulo write pending");
endmodule

// ### tb/cpu_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// cpu side of the register bus
// ----------------------------------------
module cpu_bus_model (
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [9:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
  end

  // one byte transfer; request held until pready is sampled high
  // callers read low after high clear before modulo writes
  // keep halt clear before wait clear the flag by read then zero
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### tb/modulo_timer_counter_core_bench.sv
`timescale 1ns/1ps
module modulo_timer_counter_core_bench;
  // short aliases for register indices
  localparam logic [7:0] SC = modulo_timer_pkg::IDX_STATUS_CTRL;
  localparam logic [7:0] CH = modulo_timer_pkg::IDX_CNT_HIGH;
  localparam logic [7:0] CL = modulo_timer_pkg::IDX_CNT_LOW;
  localparam logic [7:0] MH = modulo_timer_pkg::IDX_MOD_HIGH;
  localparam logic [7:0] ML = modulo_timer_pkg::IDX_MOD_LOW;
  // clock, reset, bus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  // system states and pin
  logic wait_mode = 1'b0, stop_mode = 1'b0, break_state = 1'b0, break_clear_allow = 1'b0;
  logic ext_count_clock_pin = 1'b0, port_direction_bit = 1'b1;
  // observed outputs
  logic ext_pin_oe, overflow_pulse, irq;
  logic [15:0] count_value;
  int error_cnt = 0, checks = 0, cyc = 0;
  logic [7:0] q;
  logic err;

  always #20 pclk = ~pclk;

  modulo_timer_counter_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode), .break_state(break_state),
    .break_clear_allow(break_clear_allow), .ext_count_clock_pin(ext_count_clock_pin),
    .port_direction_bit(port_direction_bit), .ext_pin_oe(ext_pin_oe), .count_value(count_value),
    .overflow_pulse(overflow_pulse), .irq(irq));
  cpu_bus_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cpu.xfer(1'b1, idx, d, q, err);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
    cpu.xfer(1'b0, idx, 8'h00, q, err);
    chk(what, {24'h0, q}, {24'h0, exp});
  endtask
  // unbounded wait; the timeout catches a hang
  task automatic wait_cnt(input logic [15:0] v);
    while (count_value !== v) @(posedge pclk);
  endtask
  // overflow with the counter left halted
  task automatic get_flag;
    wr(SC, 8'h00);
    while (overflow_pulse !== 1'b1) @(posedge pclk);
    wr(SC, 8'h20);
  endtask
  task automatic results;
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values; unmapped write must not land anywhere
  task automatic t_reset;
    rdc(SC, 8'h20, "status");
    wr(8'h2d, 8'h00);
    rdc(MH, 8'hff, "mod_hi");
    rdc(ML, 8'hff, "mod_lo");
    chk("pin_oe", ext_pin_oe, 1'b1);
    chk("halted", count_value, 16'h0000);
  endtask
  // wrap at modulo, flag, request, guarded clear
  task automatic t_wrap;
    wr(SC, 8'h30);
    wr(MH, 8'h00);
    wr(ML, 8'h05);
    wr(SC, 8'h40);
    wait_cnt(16'h0005);
    #1;
    chk("wrap", count_value, 16'h0000);
    repeat (3) @(posedge pclk);
    chk("irq_on", irq, 1'b1);
    rdc(SC, 8'hc0, "ovf");
    while (overflow_pulse !== 1'b1) @(posedge pclk);
    wr(SC, 8'h40);
    rdc(SC, 8'hc0, "kept");
    wr(SC, 8'he0);
    rdc(SC, 8'he0, "one_ignored");
    wr(SC, 8'h70);
    rdc(SC, 8'h60, "cleared");
    chk("irq_off", irq, 1'b0);
  endtask
  // high modulo write blocks the flag until the low byte
  task automatic t_modw;
    wr(MH, 8'h00);
    wr(SC, 8'h40);
    repeat (30) @(posedge pclk);
    rdc(SC, 8'h40, "blocked");
    chk("irq_blk", irq, 1'b0);
    wr(ML, 8'h05);
    repeat (10) @(posedge pclk);
    chk("irq_free", irq, 1'b1);
  endtask
  // break with clearing protected, then allowed
  task automatic t_break;
    get_flag();
    rdc(SC, 8'ha0, "armed");
    @(posedge pclk);
    break_state <= 1'b1;
    wr(SC, 8'h20);
    rdc(SC, 8'ha0, "protected");
    @(posedge pclk);
    break_state <= 1'b0;
    wr(SC, 8'h20);
    rdc(SC, 8'h20, "second_step");
    get_flag();
    @(posedge pclk);
    break_state <= 1'b1;
    break_clear_allow <= 1'b1;
    rdc(SC, 8'ha0, "flag");
    wr(SC, 8'h20);
    @(posedge pclk);
    break_state <= 1'b0;
    break_clear_allow <= 1'b0;
    rdc(SC, 8'h20, "stays_clear");
  endtask
  // wait keeps counting and refuses access; stop and break freeze
  task automatic t_modes;
    logic [15:0] v;
    wr(SC, 8'h40);
    @(posedge pclk);
    wait_mode <= 1'b1;
    v = count_value;
    repeat (10) @(posedge pclk);
    chk("wait_cnt", count_value, (v + 16'd10) % 16'd6);
    chk("wake", irq, 1'b1);
    cpu.xfer(1'b0, SC, 8'h00, q, err);
    chk("refused", err, 1'b1);
    chk("no_data", q, 8'h00);
    wait_mode <= 1'b0;
    wr(SC, 8'h00);
    for (int m = 0; m < 2; m++) begin
      @(posedge pclk);
      stop_mode <= (m == 0);
      break_state <= (m == 1);
      repeat (3) @(posedge pclk);
      v = count_value;
      repeat (20) @(posedge pclk);
      chk("frozen", count_value, v);
      stop_mode <= 1'b0;
      break_state <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("resumed", count_value != v, 1'b1);
    end
  endtask
  // every divider code, halt with clear holding zero
  task automatic t_presc;
    int n;
    for (int s = 0; s < 7; s++) begin
      wr(SC, 8'h30);
      repeat (4) @(posedge pclk);
      chk("held", count_value, 16'h0000);
      wr(SC, {5'b00000, 3'(s)});
      wait_cnt(16'h0001);
      n = 0;
      while (count_value === 16'h0001) begin
        @(posedge pclk);
        n++;
      end
      chk("period", n, 1 << s);
    end
  endtask
  // pin source: forced input, counts rising edges
  task automatic t_ext;
    wr(SC, 8'h37);
    wr(SC, 8'h07);
    repeat (2) @(posedge pclk);
    chk("pin_in", ext_pin_oe, 1'b0);
    repeat (4) begin
      repeat (3) @(posedge pclk);
      ext_count_clock_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_count_clock_pin <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    chk("pin_cnt", count_value, 16'h0004);
  endtask
  // high read latches low; a second high read must not relatch
  task automatic t_latch;
    logic [15:0] v, w;
    wr(SC, 8'h30);
    wr(MH, 8'hff);
    wr(ML, 8'hff);
    wr(SC, 8'h00);
    repeat (300) @(posedge pclk);
    wr(SC, 8'h20);
    repeat (2) @(posedge pclk);
    v = count_value;
    rdc(CH, v[15:8], "cnt_hi");
    wr(SC, 8'h00);
    repeat (50) @(posedge pclk);
    wr(SC, 8'h20);
    repeat (2) @(posedge pclk);
    w = count_value;
    rdc(CH, w[15:8], "cnt_hi2");
    rdc(CL, v[7:0], "lo_latched");
    rdc(CL, w[7:0], "lo_live");
  endtask

  // hang guard: all scenarios need well under this
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end

  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_wrap();
    t_modw();
    t_break();
    t_modes();
    t_presc();
    t_ext();
    t_latch();
    results();
  end
endmodule
